// >>> verilog/ipcs_top.sv
// Overview of operation
// - four states make one machine cycle
// - at most one fetch strobe per cycle
// - idle bit write enters idle after instruction
// - idle stops cpu clock only
// - idle freezes cpu state and port levels
// - enabled interrupt clears idle and resumes
// - reset from idle restarts at zero after three-cycle tail
// - watchdog runs in idle, resets after 512
// - reset exit skips instruction after idle entry
// - power-down bit write enters power-down
// - power-down stops cpu, peripheral and oscillator clocks, ports hold
// - reset pin ends power-down, restarts at zero
// - no watchdog wake with external clock source
// - level external interrupt wakes from power-down
// - in power-down, brownout select set, detect clear: rc on
// - reset sampled in fourth state, three-cycle tail
module ipcs_top (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// external pins
	input wire logic rst_pin_n,
	input wire logic [1:0] ext_int_n,
	// power control register write from the core
	input wire logic pwr_ctl_wr,
	input wire logic [1:0] pwr_ctl_wdata,
	// interrupt controller
	input wire logic irq_wake_req,
	input wire logic global_irq_enable,
	input wire logic [1:0] ext_int_en,
	input wire logic [1:0] ext_int_level_mode,
	// watchdog
	input wire logic wdt_timeout,
	input wire logic wdt_irq_en,
	input wire logic wdt_reset_en,
	input wire logic wdt_clear,
	// clock source and brown-out
	input wire logic clk_src_external,
	input wire logic low_power_brownout_select,
	input wire logic brownout_detect_flag,
	// sequencer outputs
	output logic [1:0] state_phase,
	output logic fetch_strobe,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic wdt_clk_en,
	output logic osc_enable,
	output logic rc_clk_enable,
	output logic port_hold,
	output logic sys_reset,
	output logic [1:0] power_control_reg
);
	// ======================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [2:0] pin_meta_reg;
	logic [2:0] pin_sync_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_reg <= 2'h0;
		else if (clk_en)
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// pins are idle high; the meta stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pin_meta_reg <= 3'h7;
		else if (clk_en)
			pin_meta_reg <= {ext_int_n, rst_pin_n};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pin_sync_reg <= 3'h7;
		else if (clk_en)
			pin_sync_reg <= pin_meta_reg;
	end

	// ======================================================
	// machine cycle phases
	ipcs_phase_if ph ();

	ipcs_phase_gen u_phase (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.ph(ph)
	);

	// ======================================================
	// state
	ipcs_pkg::ipcs_mode_t mode_reg;
	ipcs_pkg::ipcs_mode_t mode_next;
	logic [1:0] pwr_ctl_next;
	logic [1:0] hold_cnt_reg;
	logic [1:0] hold_cnt_next;
	logic reset_next;
	logic wdt_reset_pulse;

	// ======================================================
	// decode
	wire in_run = (mode_reg == ipcs_pkg::MODE_RUN);
	wire in_idle = (mode_reg == ipcs_pkg::MODE_IDLE);
	wire in_pdown = (mode_reg == ipcs_pkg::MODE_PDOWN);
	wire rst_pin_low = !pin_sync_reg[0];
	wire [1:0] ext_int_active = ~pin_sync_reg[2:1];

	// the cpu and peripheral clocks stop in power-down, so the phase counter freezes there
	assign ph.step_en = !in_pdown;

	wire sample_point = ph.cycle_end;
	wire pwr_ctl_pending = |power_control_reg;

	// wake sources
	wire wdt_wake = wdt_timeout && wdt_irq_en && global_irq_enable;
	wire idle_wake = in_idle && (irq_wake_req || wdt_wake);
	wire [1:0] lvl_wake = ext_int_active & ext_int_en & ~ext_int_level_mode;
	wire pd_int_wake = in_pdown && global_irq_enable && (|lvl_wake);
	wire pd_rst_wake = in_pdown && rst_pin_low;

	// watchdog counts unless its clock is stopped by power-down
	wire wdt_count_en = !in_pdown || !clk_src_external;

	ipcs_wdt_reset u_wdt (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.count_en(wdt_count_en),
		.timeout_evt(wdt_timeout),
		.wdt_clear(wdt_clear),
		.reset_en(wdt_reset_en),
		.wdt_reset_pulse(wdt_reset_pulse)
	);

	// ======================================================
	// internal reset: pin sampled in the fourth state, tail of three cycles
	always_comb begin
		reset_next = sys_reset;
		hold_cnt_next = hold_cnt_reg;
		if (wdt_reset_pulse) begin
			reset_next = 1'b1;
			hold_cnt_next = ipcs_pkg::RST_HOLD_CYCLES;
		end else if (sample_point && rst_pin_low) begin
			reset_next = 1'b1;
			hold_cnt_next = ipcs_pkg::RST_HOLD_CYCLES;
		end else if (sample_point && sys_reset) begin
			if (hold_cnt_reg == ipcs_pkg::RST_HOLD_DONE)
				reset_next = 1'b0;
			else
				hold_cnt_next = hold_cnt_reg - 2'h1;
		end
	end

	// ======================================================
	// power control bits and mode
	always_comb begin
		pwr_ctl_next = power_control_reg;
		if (pwr_ctl_wr && in_run && !sys_reset)
			pwr_ctl_next = pwr_ctl_wdata;
		if (idle_wake)
			pwr_ctl_next[ipcs_pkg::PWR_CTL_IDLE_BIT] = 1'b0;
		if (pd_int_wake || pd_rst_wake)
			pwr_ctl_next[ipcs_pkg::PWR_CTL_PDOWN_BIT] = 1'b0;
		if (reset_next)
			pwr_ctl_next = ipcs_pkg::PWR_CTL_RESET;
	end

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			ipcs_pkg::MODE_RUN: begin
				// mode changes at the cycle boundary after the writing instruction
				if (ph.cycle_end && !sys_reset) begin
					if (power_control_reg[ipcs_pkg::PWR_CTL_PDOWN_BIT])
						mode_next = ipcs_pkg::MODE_PDOWN;
					else if (power_control_reg[ipcs_pkg::PWR_CTL_IDLE_BIT])
						mode_next = ipcs_pkg::MODE_IDLE;
				end
			end
			ipcs_pkg::MODE_IDLE: begin
				if (idle_wake || reset_next)
					mode_next = ipcs_pkg::MODE_RUN;
			end
			ipcs_pkg::MODE_PDOWN: begin
				if (pd_int_wake || pd_rst_wake || reset_next)
					mode_next = ipcs_pkg::MODE_RUN;
			end
			default: mode_next = ipcs_pkg::MODE_RUN;
		endcase
	end

	// ======================================================
	// output decode
	wire run_next = (mode_next == ipcs_pkg::MODE_RUN);
	wire pdown_next = (mode_next == ipcs_pkg::MODE_PDOWN);
	wire [1:0] phase_after = ph.step_en ? ph.phase + 2'h1 : ph.phase;
	// no fetch once a mode bit is pending, so the writer is the last instruction,
	// and none while reset holds, so nothing after the entry runs on a reset exit
	wire fetch_next = run_next && !reset_next && !pwr_ctl_pending && ph.step_en &&
		(phase_after == ipcs_pkg::STATE_FIRST);
	wire rc_next = pdown_next && low_power_brownout_select &&
		!brownout_detect_flag;

	// ======================================================
	// registers
	// one short block per register keeps each reset value beside its update
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= ipcs_pkg::MODE_RUN;
		else if (clk_en)
			mode_reg <= mode_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			power_control_reg <= ipcs_pkg::PWR_CTL_RESET;
		else if (clk_en)
			power_control_reg <= pwr_ctl_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			sys_reset <= 1'b1;
		else if (clk_en)
			sys_reset <= reset_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			hold_cnt_reg <= ipcs_pkg::RST_HOLD_CYCLES;
		else if (clk_en)
			hold_cnt_reg <= hold_cnt_next;
	end

	// ======================================================
	// output flops: every pin of the sequencer leaves from a flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			fetch_strobe <= 1'b0;
		else if (clk_en)
			fetch_strobe <= fetch_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cpu_clk_en <= 1'b1;
		else if (clk_en)
			cpu_clk_en <= run_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			periph_clk_en <= 1'b1;
		else if (clk_en)
			periph_clk_en <= !pdown_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wdt_clk_en <= 1'b1;
		else if (clk_en)
			wdt_clk_en <= !pdown_next || !clk_src_external;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			osc_enable <= 1'b1;
		else if (clk_en)
			osc_enable <= !pdown_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rc_clk_enable <= 1'b0;
		else if (clk_en)
			rc_clk_enable <= rc_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			port_hold <= 1'b0;
		else if (clk_en)
			port_hold <= !run_next;
	end

	assign state_phase = ph.phase;
endmodule : ipcs_top

// >>> verilog/ipcs_pkg.sv
package ipcs_pkg;
	// ======================================================
	// machine cycle states
	localparam logic [1:0] STATE_FIRST = 2'h0;
	localparam logic [1:0] STATE_SECOND = 2'h1;
	localparam logic [1:0] STATE_THIRD = 2'h2;
	localparam logic [1:0] STATE_FOURTH = 2'h3;
	localparam int STATES_PER_CYCLE = 4;

	// ======================================================
	// power control register fields
	localparam int PWR_CTL_IDLE_BIT = 0;
	localparam int PWR_CTL_PDOWN_BIT = 1;
	localparam logic [1:0] PWR_CTL_RESET = 2'h0;

	// ======================================================
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int WDT_RST_DELAY_CLKS = 512;
	localparam logic [9:0] WDT_CNT_LAST = 10'(WDT_RST_DELAY_CLKS - 1);
	localparam logic [9:0] WDT_CNT_ZERO = 10'h000;
	localparam logic [1:0] RST_HOLD_CYCLES = 2'h2;
	localparam logic [1:0] RST_HOLD_DONE = 2'h0;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// ======================================================
	// power modes
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_IDLE = 2'b01,
		MODE_PDOWN = 2'b10
	} ipcs_mode_t;
endpackage : ipcs_pkg

// >>> verilog/ipcs_phase_if.sv
interface ipcs_phase_if;
	logic [1:0] phase;
	logic step_en;
	logic cycle_end;

	modport gen (output phase, output cycle_end, input step_en);
	modport user (input phase, input cycle_end, output step_en);
endinterface : ipcs_phase_if

// >>> verilog/ipcs_phase_gen.sv
module ipcs_phase_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// phase carrier
	ipcs_phase_if.gen ph
);
	logic [1:0] phase_reg;
	logic [1:0] phase_next;

	// states wrap first, second, third, fourth, first ...
	assign phase_next = phase_reg + 2'h1;
	assign ph.phase = phase_reg;
	assign ph.cycle_end = ph.step_en && (phase_reg == ipcs_pkg::STATE_FOURTH);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			phase_reg <= ipcs_pkg::STATE_FIRST;
		else if (clk_en && ph.step_en)
			phase_reg <= phase_next;
	end
endmodule : ipcs_phase_gen

// >>> verilog/ipcs_wdt_reset.sv
module ipcs_wdt_reset (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// watchdog side
	input wire logic count_en,
	input wire logic timeout_evt,
	input wire logic wdt_clear,
	input wire logic reset_en,
	// result
	output logic wdt_reset_pulse
);
	logic armed_reg;
	logic [9:0] cnt_reg;
	logic expire;

	assign expire = armed_reg && count_en && (cnt_reg == ipcs_pkg::WDT_CNT_LAST);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
			cnt_reg <= ipcs_pkg::WDT_CNT_ZERO;
			wdt_reset_pulse <= 1'b0;
		end else if (clk_en) begin
			wdt_reset_pulse <= expire;
			// a new time-out wins over a clear in the same cycle
			if (timeout_evt && reset_en) begin
				armed_reg <= 1'b1;
				cnt_reg <= ipcs_pkg::WDT_CNT_ZERO;
			end else if (wdt_clear || expire) begin
				armed_reg <= 1'b0;
			end else if (armed_reg && count_en) begin
				cnt_reg <= cnt_reg + 10'h001;
			end
		end
	end
endmodule : ipcs_wdt_reset

// >>> bench/ipcs_top_asserts.sv
module ipcs_top_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// clock source and brown-out inputs
	input wire logic clk_src_external,
	input wire logic low_power_brownout_select,
	input wire logic brownout_detect_flag,
	// sequencer outputs
	input wire logic [1:0] state_phase,
	input wire logic fetch_strobe,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic wdt_clk_en,
	input wire logic osc_enable,
	input wire logic rc_clk_enable,
	input wire logic port_hold,
	input wire logic sys_reset,
	input wire logic [1:0] power_control_reg
);
	// ======================================================
	// assertions
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_fetch_first: assert property (fetch_strobe |-> state_phase == ipcs_pkg::STATE_FIRST)
		else $error("fetch strobe outside the first state");
	a_fetch_once: assert property (fetch_strobe |=> !fetch_strobe [*3])
		else $error("second fetch within one machine cycle");
	a_phase_step: assert property (state_phase != $past(state_phase) |->
		state_phase == $past(state_phase) + 2'h1) else $error("state order broken");
	a_idle_cpu: assert property (port_hold && periph_clk_en |-> !cpu_clk_en && osc_enable)
		else $error("idle clock gating wrong");
	a_pdown_stop: assert property (!periph_clk_en |-> !cpu_clk_en && !osc_enable && port_hold)
		else $error("power-down left a clock running");
	a_both_pdown: assert property (power_control_reg == 2'h3 && port_hold |-> !periph_clk_en)
		else $error("idle taken over power-down");
	a_rc_clock: assert property (rc_clk_enable == (!periph_clk_en &&
		$past(low_power_brownout_select) && !$past(brownout_detect_flag)))
		else $error("rc clock enable wrong");
	a_wdt_clock: assert property (wdt_clk_en == !(!periph_clk_en && $past(clk_src_external)))
		else $error("watchdog clock wrong in power-down");
	a_no_fetch_rst: assert property (sys_reset && $past(sys_reset) |-> !fetch_strobe)
		else $error("fetch during reset");
	a_rst_release: assert property ($fell(sys_reset) |-> state_phase == ipcs_pkg::STATE_FIRST)
		else $error("reset released off the fourth state");
	a_rst_clears: assert property ($rose(sys_reset) |-> ##2 power_control_reg == 2'h0)
		else $error("mode bits survive reset");
	cover property (port_hold && periph_clk_en);
	cover property (rc_clk_enable);
	cover property ($fell(sys_reset));
endmodule : ipcs_top_checker

bind ipcs_top ipcs_top_checker u_chk (.mclk, .reset_n, .clk_src_external,
	.low_power_brownout_select, .brownout_detect_flag, .state_phase, .fetch_strobe,
	.cpu_clk_en, .periph_clk_en, .wdt_clk_en, .osc_enable, .rc_clk_enable, .port_hold,
	.sys_reset, .power_control_reg);

// >>> bench/ipcs_pin_model.sv
module ipcs_pin_model (
	// clock
	input wire logic mclk,
	// requests from the bench
	input wire logic rst_req,
	input wire logic [1:0] int_level,
	// pins
	output logic rst_pin_n,
	output logic [1:0] ext_int_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ======================================================
	// reset pin: 12 clocks gives two fourth-state samples plus sync slack
	logic [3:0] hold_reg = 4'h0;
	always_ff @(posedge mclk) begin
		if (rst_req)
			hold_reg <= 4'hc;
		else if (hold_reg != 4'h0)
			hold_reg <= hold_reg - 4'h1;
	end
	assign rst_pin_n = (hold_reg == 4'h0);
	// level sources keep the pin low until the bench lets go
	assign ext_int_n = ~int_level;
endmodule : ipcs_pin_model

// >>> bench/tb_idle_powerdown_clock_sequencer.sv
module tb_idle_powerdown_clock_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, rst_req = 1'b0, pwr_ctl_wr = 1'b0;
	logic irq_wake_req = 1'b0, global_irq_enable = 1'b1, wdt_timeout = 1'b0, wdt_irq_en = 1'b1;
	logic wdt_reset_en = 1'b0, wdt_clear = 1'b0, clk_src_external = 1'b0;
	logic low_power_brownout_select = 1'b0, brownout_detect_flag = 1'b0;
	logic [1:0] pwr_ctl_wdata = 2'h0, ext_int_en = 2'h0, ext_int_level_mode = 2'h3;
	logic [1:0] int_level = 2'h0;
	logic rst_pin_n, fetch_strobe, cpu_clk_en, periph_clk_en, wdt_clk_en, osc_enable;
	logic rc_clk_enable, port_hold, sys_reset;
	logic [1:0] ext_int_n, state_phase, power_control_reg, ph;
	int miscompares = 0, checked = 0, cycles = 0, n;

	ipcs_pin_model FAR (.mclk, .rst_req, .int_level, .rst_pin_n, .ext_int_n);
	ipcs_top DUT (.mclk, .reset_n, .clk_en, .rst_pin_n, .ext_int_n, .pwr_ctl_wr, .pwr_ctl_wdata,
		.irq_wake_req, .global_irq_enable, .ext_int_en, .ext_int_level_mode, .wdt_timeout,
		.wdt_irq_en, .wdt_reset_en, .wdt_clear, .clk_src_external, .low_power_brownout_select,
		.brownout_detect_flag, .state_phase, .fetch_strobe, .cpu_clk_en, .periph_clk_en,
		.wdt_clk_en, .osc_enable, .rc_clk_enable, .port_hold, .sys_reset, .power_control_reg);

	// ======================================================
	// tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	task write_pwr_ctl(input logic [1:0] v);
		@(posedge mclk);
		pwr_ctl_wr <= 1'b1;
		pwr_ctl_wdata <= v;
		@(posedge mclk);
		pwr_ctl_wr <= 1'b0;
		#1;
	endtask : write_pwr_ctl
	task pin_reset;
		@(posedge mclk) rst_req <= 1'b1;
		@(posedge mclk) rst_req <= 1'b0;
		while (sys_reset !== 1'b1) tick(1);
		while (sys_reset !== 1'b0) tick(1);
	endtask : pin_reset
	task end_sim;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// ======================================================
	// clock, hang guard and sequence
	initial forever #2.5 mclk = ~mclk;
	// whole sequence needs about 1400 clocks
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		tick(3);
		@(posedge mclk) reset_n <= 1'b1;
		while (sys_reset !== 1'b0) tick(1);
		check({power_control_reg, cpu_clk_en, periph_clk_en, osc_enable, port_hold}, 6'h0e);
		n = 0;
		repeat (16) begin
			tick(1);
			n += (fetch_strobe === 1'b1);
		end
		check(16'(n), 16'h4);
		write_pwr_ctl(2'h1);
		check(power_control_reg, 2'h1);
		while (port_hold !== 1'b1) tick(1);
		check({cpu_clk_en, periph_clk_en, wdt_clk_en, osc_enable}, 4'h7);
		write_pwr_ctl(2'h2);
		tick(8);
		check({power_control_reg, cpu_clk_en}, 3'h2);
		@(posedge mclk) irq_wake_req <= 1'b1;
		while (cpu_clk_en !== 1'b1) tick(1);
		check({power_control_reg, port_hold}, 3'h0);
		@(posedge mclk) irq_wake_req <= 1'b0;
		write_pwr_ctl(2'h1);
		while (port_hold !== 1'b1) tick(1);
		@(posedge mclk) wdt_timeout <= 1'b1;
		@(posedge mclk) wdt_timeout <= 1'b0;
		tick(3);
		check({cpu_clk_en, power_control_reg}, 3'h4);
		@(posedge mclk) begin
			clk_src_external <= 1'b1;
			low_power_brownout_select <= 1'b1;
			ext_int_en <= 2'h2;
			ext_int_level_mode <= 2'h1;
		end
		write_pwr_ctl(2'h2);
		while (osc_enable !== 1'b0) tick(1);
		check({cpu_clk_en, periph_clk_en, wdt_clk_en, rc_clk_enable, port_hold}, 5'h03);
		ph = state_phase;
		@(posedge mclk) int_level <= 2'h1;
		tick(10);
		check({state_phase, osc_enable}, {ph, 1'b0});
		@(posedge mclk) int_level <= 2'h2;
		while (osc_enable !== 1'b1) tick(1);
		@(posedge mclk) int_level <= 2'h0;
		tick(1);
		check(power_control_reg, 2'h0);
		write_pwr_ctl(2'h3);
		tick(8);
		check({power_control_reg, periph_clk_en, cpu_clk_en}, 4'hc);
		pin_reset();
		check({power_control_reg, osc_enable, port_hold}, 4'h2);
		write_pwr_ctl(2'h1);
		while (port_hold !== 1'b1) tick(1);
		pin_reset();
		check({power_control_reg, cpu_clk_en, port_hold}, 4'h2);
		@(posedge mclk) begin
			wdt_reset_en <= 1'b1;
			clk_src_external <= 1'b0;
			wdt_timeout <= 1'b1;
		end
		@(posedge mclk) wdt_timeout <= 1'b0;
		n = 0;
		while (sys_reset !== 1'b1) begin
			tick(1);
			n++;
		end
		check(16'(n >= 512 && n <= 518), 16'h1);
		while (sys_reset !== 1'b0) tick(1);
		@(posedge mclk) wdt_timeout <= 1'b1;
		@(posedge mclk) wdt_timeout <= 1'b0;
		tick(100);
		@(posedge mclk) wdt_clear <= 1'b1;
		@(posedge mclk) wdt_clear <= 1'b0;
		tick(600);
		check(sys_reset, 1'b0);
		end_sim();
	end
endmodule : tb_idle_powerdown_clock_sequencer
